// File: core/sbl_loader.sv
// Purpose: Boot loader that fills system RAM from a UART host or a serial memory.
// Assumes: External UART, SPI and I2C engines move bytes; this block runs the protocol.
// Notes:   Tags below mark the logic that keeps each rule.
// Behaviour
// [R1] Start serial download only if receive line high.
// [R2] Open serial session by sending start byte.
// [R3] Host sends header byte, then length low first.
// [R4] After three header bytes reply ACK, else NACK.
// [R5] Host sends N bytes; store them consecutively.
// [R6] Send XOR checksum of code bytes from zero.
// [R7] Host answers ACK on match; ACK completes download.
// [R8] Release serial pins before handing over control.
// [R9] Finally execute code at system RAM base.
// [R10] Branch with ROM at zero, or remap and reset.
// [R11] Serial download plus one memory source allowed.
// [R12] SPI boot: init port, check signature bytes.
// [R13] SPI header: size bytes 6,7; code from 8.
// [R14] EEPROM boot: init port, check signature bytes.
// [R15] EEPROM header: size 2,3, checksum 4, code 32.
// [R16] EEPROM: start code only when checksum matches.
// [R17] Bad signature or checksum: stay in boot.

`timescale 1ns/1ps
`default_nettype none

module sbl_loader
    import sbl_pkg::*;
(
    input  wire logic        sys_clk_in,       // System clock, 100 MHz.
    input  wire logic        rst_n_in,         // Asynchronous reset, active low.
    input  wire logic        ce_in,            // Clock enable; all state holds when low.
    input  wire logic        uart_rxd_in,      // Raw receive pin level.
    input  wire logic        uart_enable_in,   // Serial download allowed.
    input  wire logic        mem_enable_in,    // Memory boot allowed.
    input  wire sbl_src_e    mem_src_in,       // Which memory source is built in.
    input  wire logic        app_at_zero_in,   // Loaded code is linked at address zero.
    input  wire sbl_byte_s   rx_byte_in,       // Received byte, valid is a pulse.
    input  wire logic        tx_ready_in,      // Transmitter takes tx byte.
    input  wire logic        mem_init_done_in, // Memory port and device ready.
    input  wire sbl_byte_s   mem_rd_in,        // Read data, valid is a pulse.
    output sbl_byte_s        tx_byte_out,      // Byte to transmit, held until taken.
    output sbl_ram_wr_s      ram_wr_out,       // System RAM byte write.
    output sbl_mem_rd_s      mem_rd_out,       // Memory byte read request pulse.
    output logic             mem_init_out,     // Memory init request pulse.
    output logic             uart_claim_out,   // Serial pins held by loader.
    output logic             remap_zero_out,   // Address zero mapped to RAM.
    output logic             sw_reset_out,     // Software reset pulse.
    output logic             branch_out,       // Branch pulse.
    output logic [31:0]      jump_addr_out,    // Code start address.
    output logic             boot_done_out,    // Control handed to loaded code.
    output logic             boot_fail_out     // Boot failed: memory image rejected, or memory boot disabled and no serial download started.
);

    // ****************************************************************
    // State encoding.
    // ****************************************************************
    typedef enum logic [12:0] {
        ST_SETTLE   = 13'h0001,
        ST_TX_STX   = 13'h0002,
        ST_RX_HDR   = 13'h0004,
        ST_TX_REPLY = 13'h0008,
        ST_RX_CODE  = 13'h0010,
        ST_TX_CSUM  = 13'h0020,
        ST_RX_FINAL = 13'h0040,
        ST_MEM_INIT = 13'h0080,
        ST_MEM_HDR  = 13'h0100,
        ST_MEM_CODE = 13'h0200,
        ST_HANDOVER = 13'h0400,
        ST_DONE     = 13'h0800,
        ST_FAIL     = 13'h1000
    } sbl_state_e;

    sbl_state_e  state_r;
    logic [2:0]  rxd_sync_r;
    logic        rx_level_r;
    logic [3:0]  settle_cnt_r;
    logic [15:0] idx_r;
    logic [15:0] len_r;
    logic [7:0]  csum_r;
    logic [7:0]  exp_csum_r;
    logic        reply_ack_r;
    logic        tx_fire;
    logic        last_hdr;
    logic [15:0] len_now;
    logic [7:0]  csum_now;
    logic [23:0] code_base;

    assign tx_fire   = tx_byte_out.valid && tx_ready_in;
    assign code_base = (mem_src_in == SBL_SRC_SPI) ? SBL_SPI_CODE : SBL_EE_CODE;
    assign last_hdr  = (mem_src_in == SBL_SRC_SPI) ? (idx_r == SBL_SPI_SIZE_LO)
                                                   : (idx_r == SBL_EE_CSUM);
    assign len_now   = (mem_src_in == SBL_SRC_SPI) ? {len_r[15:8], mem_rd_in.data} : len_r;
    assign csum_now  = csum_r ^ mem_rd_in.data;

    // ****************************************************************
    // Receive pin filter: three flops, level taken when last two agree.
    // ****************************************************************
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rxd_sync_r <= 3'h0;
            rx_level_r <= 1'b0;
        end else if (ce_in) begin
            rxd_sync_r <= {rxd_sync_r[1:0], uart_rxd_in};
            if (rxd_sync_r[1] == rxd_sync_r[2]) begin
                rx_level_r <= rxd_sync_r[2];
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            settle_cnt_r <= 4'h0;
        end else if (ce_in && state_r == ST_SETTLE && settle_cnt_r != SBL_SETTLE_CYC) begin
            settle_cnt_r <= settle_cnt_r + 4'h1;
        end
    end

    // ****************************************************************
    // Boot sequencer.
    // ****************************************************************
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r        <= ST_SETTLE;
            idx_r          <= 16'h0;
            len_r          <= 16'h0;
            csum_r         <= SBL_CSUM_INIT;
            exp_csum_r     <= 8'h00;
            reply_ack_r    <= 1'b0;
            tx_byte_out    <= '0;
            ram_wr_out     <= '0;
            mem_rd_out     <= '0;
            mem_init_out   <= 1'b0;
            uart_claim_out <= 1'b0;
            remap_zero_out <= 1'b0;
            sw_reset_out   <= 1'b0;
            branch_out     <= 1'b0;
            jump_addr_out  <= 32'h0;
            boot_done_out  <= 1'b0;
            boot_fail_out  <= 1'b0;
        end else if (ce_in) begin
            ram_wr_out.we  <= 1'b0;
            mem_rd_out.req <= 1'b0;
            mem_init_out   <= 1'b0;
            sw_reset_out   <= 1'b0;
            branch_out     <= 1'b0;
            if (tx_fire) begin
                tx_byte_out.valid <= 1'b0;
            end
            case (state_r)
                ST_SETTLE: begin
                    if (settle_cnt_r == SBL_SETTLE_CYC) begin
                        if (uart_enable_in && rx_level_r) begin // see [R1]
                            state_r        <= ST_TX_STX;
                            uart_claim_out <= 1'b1;
                            tx_byte_out    <= '{valid: 1'b1, data: SBL_STX}; // see [R2]
                        end else if (mem_enable_in) begin // see [R11]
                            state_r      <= ST_MEM_INIT;
                            mem_init_out <= 1'b1; // see [R12] see [R14]
                        end else begin
                            state_r       <= ST_FAIL;
                            boot_fail_out <= 1'b1;
                        end
                    end
                end
                ST_TX_STX: begin
                    if (tx_fire) begin
                        state_r <= ST_RX_HDR;
                        idx_r   <= 16'h0;
                    end
                end
                ST_RX_HDR: begin
                    if (rx_byte_in.valid) begin // see [R3]
                        idx_r <= idx_r + 16'h1;
                        case (idx_r[1:0])
                            2'h0:    reply_ack_r <= (rx_byte_in.data == SBL_SOH);
                            2'h1:    len_r[7:0]  <= rx_byte_in.data;
                            default: begin
                                len_r[15:8] <= rx_byte_in.data;
                                state_r     <= ST_TX_REPLY;
                                tx_byte_out <= '{valid: 1'b1,
                                                 data: reply_ack_r ? SBL_ACK : SBL_NACK}; // see [R4]
                            end
                        endcase
                    end
                end
                ST_TX_REPLY: begin
                    if (tx_fire) begin
                        idx_r  <= 16'h0;
                        csum_r <= SBL_CSUM_INIT;
                        if (!reply_ack_r) begin
                            state_r     <= ST_TX_STX;
                            tx_byte_out <= '{valid: 1'b1, data: SBL_STX};
                        end else if (len_r == 16'h0) begin
                            state_r     <= ST_TX_CSUM;
                            tx_byte_out <= '{valid: 1'b1, data: SBL_CSUM_INIT};
                        end else begin
                            state_r <= ST_RX_CODE;
                        end
                    end
                end
                ST_RX_CODE: begin
                    if (rx_byte_in.valid) begin
                        ram_wr_out <= '{we: 1'b1, addr: SBL_RAM_BASE + {16'h0, idx_r},
                                        data: rx_byte_in.data}; // see [R5]
                        csum_r     <= csum_r ^ rx_byte_in.data; // see [R6]
                        idx_r      <= idx_r + 16'h1;
                        if (idx_r == len_r - 16'h1) begin
                            state_r     <= ST_TX_CSUM;
                            tx_byte_out <= '{valid: 1'b1, data: csum_r ^ rx_byte_in.data};
                        end
                    end
                end
                ST_TX_CSUM: begin
                    if (tx_fire) begin
                        state_r <= ST_RX_FINAL;
                    end
                end
                ST_RX_FINAL: begin
                    if (rx_byte_in.valid) begin
                        if (rx_byte_in.data == SBL_ACK) begin // see [R7]
                            state_r <= ST_HANDOVER;
                        end else begin
                            state_r     <= ST_TX_STX;
                            tx_byte_out <= '{valid: 1'b1, data: SBL_STX};
                        end
                    end
                end
                ST_MEM_INIT: begin
                    if (mem_init_done_in) begin
                        state_r    <= ST_MEM_HDR;
                        idx_r      <= 16'h0;
                        csum_r     <= SBL_CSUM_INIT;
                        mem_rd_out <= '{req: 1'b1, addr: 24'h0};
                    end
                end
                ST_MEM_HDR: begin
                    if (mem_rd_in.valid) begin
                        idx_r <= idx_r + 16'h1;
                        if ((idx_r == 16'h0 && mem_rd_in.data != SBL_SIG0) ||
                            (idx_r == SBL_IDX_SIG1 && mem_rd_in.data != SBL_SIG1)) begin
                            state_r       <= ST_FAIL; // see [R17]
                            boot_fail_out <= 1'b1;
                        end else begin
                            if (mem_src_in == SBL_SRC_SPI) begin // see [R13]
                                if (idx_r == SBL_SPI_SIZE_HI) len_r[15:8] <= mem_rd_in.data;
                                if (idx_r == SBL_SPI_SIZE_LO) len_r[7:0]  <= mem_rd_in.data;
                            end else begin // see [R15]
                                if (idx_r == SBL_EE_SIZE_HI) len_r[15:8] <= mem_rd_in.data;
                                if (idx_r == SBL_EE_SIZE_LO) len_r[7:0]  <= mem_rd_in.data;
                                if (idx_r == SBL_EE_CSUM)    exp_csum_r  <= mem_rd_in.data;
                            end
                            if (!last_hdr) begin
                                mem_rd_out <= '{req: 1'b1, addr: {8'h0, idx_r + 16'h1}};
                            end else if (len_now != 16'h0) begin
                                state_r    <= ST_MEM_CODE;
                                idx_r      <= 16'h0;
                                mem_rd_out <= '{req: 1'b1, addr: code_base};
                            end else if (mem_src_in == SBL_SRC_EEPROM &&
                                         mem_rd_in.data != SBL_CSUM_INIT) begin
                                state_r       <= ST_FAIL;
                                boot_fail_out <= 1'b1;
                            end else begin
                                state_r <= ST_HANDOVER;
                            end
                        end
                    end
                end
                ST_MEM_CODE: begin
                    if (mem_rd_in.valid) begin
                        ram_wr_out <= '{we: 1'b1, addr: SBL_RAM_BASE + {16'h0, idx_r},
                                        data: mem_rd_in.data};
                        csum_r     <= csum_now;
                        idx_r      <= idx_r + 16'h1;
                        if (idx_r != len_r - 16'h1) begin
                            mem_rd_out <= '{req: 1'b1,
                                            addr: code_base + {8'h0, idx_r + 16'h1}};
                        end else if (mem_src_in == SBL_SRC_EEPROM &&
                                     csum_now != exp_csum_r) begin
                            state_r       <= ST_FAIL; // see [R16] see [R17]
                            boot_fail_out <= 1'b1;
                        end else begin
                            state_r <= ST_HANDOVER;
                        end
                    end
                end
                ST_HANDOVER: begin
                    uart_claim_out <= 1'b0; // see [R8]
                    state_r        <= ST_DONE;
                end
                ST_DONE: begin
                    if (!boot_done_out) begin
                        boot_done_out  <= 1'b1;
                        jump_addr_out  <= SBL_RAM_BASE; // see [R9]
                        remap_zero_out <= app_at_zero_in; // see [R10]
                        sw_reset_out   <= app_at_zero_in;
                        branch_out     <= !app_at_zero_in;
                    end
                end
                ST_FAIL: begin
                    state_r <= ST_FAIL;
                end
                default: begin
                    state_r <= ST_FAIL;
                end
            endcase
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_final_ack;
        ce_in && state_r == ST_RX_FINAL && rx_byte_in.valid && rx_byte_in.data == SBL_ACK;
    endsequence

    sequence s_handover_then_start;
        state_r == ST_HANDOVER && ce_in ##1 ce_in && !uart_claim_out && !boot_done_out;
    endsequence

    AST_RX_GATE: assert property ( // see [R1]
        $past(state_r) == ST_SETTLE && state_r == ST_TX_STX |-> $past(rx_level_r))
        else $error("Serial download started with receive line low.");

    AST_STX_BYTE: assert property ( // see [R2]
        state_r == ST_TX_STX && tx_byte_out.valid |-> tx_byte_out.data == SBL_STX)
        else $error("Session opened without start byte.");

    AST_REPLY: assert property ( // see [R4]
        state_r == ST_TX_REPLY && tx_byte_out.valid
        |-> tx_byte_out.data == (reply_ack_r ? SBL_ACK : SBL_NACK))
        else $error("Header reply does not match header check.");

    AST_RAM_ADDR: assert property ( // see [R5]
        ram_wr_out.we |-> ram_wr_out.addr == SBL_RAM_BASE + {16'h0, idx_r - 16'h1})
        else $error("Code byte stored out of sequence.");

    AST_CSUM_SEND: assert property ( // see [R6]
        state_r == ST_TX_CSUM && tx_byte_out.valid |-> tx_byte_out.data == csum_r)
        else $error("Sent checksum differs from running XOR.");

    AST_FINAL_ACK: assert property ( // see [R7]
        s_final_ack |=> state_r == ST_HANDOVER)
        else $error("Final acknowledge did not complete download.");

    AST_RELEASE_FIRST: assert property ( // see [R8]
        s_handover_then_start |=> boot_done_out && !uart_claim_out)
        else $error("Serial pins not released before start.");

    AST_JUMP: assert property ( // see [R9] see [R10]
        $rose(boot_done_out) |-> jump_addr_out == SBL_RAM_BASE &&
        (sw_reset_out == app_at_zero_in || $past(ce_in) == 1'b0) && (branch_out != sw_reset_out) &&
        (remap_zero_out == sw_reset_out))
        else $error("Hand-over target or method wrong.");

    AST_SIG: assert property ( // see [R12] see [R14]
        ce_in && state_r == ST_MEM_HDR && mem_rd_in.valid && idx_r == SBL_IDX_SIG1 &&
        mem_rd_in.data != SBL_SIG1 |=> state_r == ST_FAIL)
        else $error("Bad signature accepted.");

    AST_STAY_FAIL: assert property ( // see [R16] see [R17]
        state_r == ST_FAIL |=> state_r == ST_FAIL && !boot_done_out && !branch_out)
        else $error("Rejected image handed control.");

endmodule

`default_nettype wire

// File: core/sbl_pkg.sv
// Purpose: Shared constants and carrier types for the secondary boot image loader.
// Assumes: 100 MHz system clock; byte-level UART, memory and RAM ports outside.
// Notes:   One name for each protocol byte, header offset and timing count.

`default_nettype none

package sbl_pkg;

    // ****************************************************************
    // Protocol bytes.
    // ****************************************************************
    localparam logic [7:0] SBL_STX       = 8'h02;
    localparam logic [7:0] SBL_SOH       = 8'h01;
    localparam logic [7:0] SBL_ACK       = 8'h06;
    localparam logic [7:0] SBL_NACK      = 8'h15;
    localparam logic [7:0] SBL_CSUM_INIT = 8'h00;
    localparam logic [7:0] SBL_SIG0      = 8'h70;
    localparam logic [7:0] SBL_SIG1      = 8'h50;

    // ****************************************************************
    // Address map and image header offsets.
    // ****************************************************************
    localparam logic [31:0] SBL_RAM_BASE    = 32'h2000_0000;
    localparam logic [15:0] SBL_IDX_SIG1    = 16'h0001;
    localparam logic [15:0] SBL_SPI_SIZE_HI = 16'h0006;
    localparam logic [15:0] SBL_SPI_SIZE_LO = 16'h0007;
    localparam logic [23:0] SBL_SPI_CODE    = 24'h00_0008;
    localparam logic [15:0] SBL_EE_SIZE_HI  = 16'h0002;
    localparam logic [15:0] SBL_EE_SIZE_LO  = 16'h0003;
    localparam logic [15:0] SBL_EE_CSUM     = 16'h0004;
    localparam logic [23:0] SBL_EE_CODE     = 24'h00_0020;

    // ****************************************************************
    // Timing: settle time of the receive-line filter before it is read.
    // ****************************************************************
    localparam int          SBL_CLK_PERIOD_NS = 10;
    localparam int          SBL_SETTLE_NS     = 40;
    localparam logic [3:0]  SBL_SETTLE_CYC    =
        4'((SBL_SETTLE_NS + SBL_CLK_PERIOD_NS - 1) / SBL_CLK_PERIOD_NS);

    // ****************************************************************
    // Types.
    // ****************************************************************
    typedef enum logic {
        SBL_SRC_SPI    = 1'b0,
        SBL_SRC_EEPROM = 1'b1
    } sbl_src_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } sbl_byte_s;

    typedef struct packed {
        logic        we;
        logic [31:0] addr;
        logic [7:0]  data;
    } sbl_ram_wr_s;

    typedef struct packed {
        logic        req;
        logic [23:0] addr;
    } sbl_mem_rd_s;

endpackage

`default_nettype wire

// File: sim/sbl_loader_tb_top.sv
// Purpose: Self-checking bench for the secondary boot image loader.
// Assumes: The bench plays the serial host; a model plays the boot memory.
// Notes:   Monitors collect sent bytes and RAM writes for the scenarios.
`timescale 1ns/1ps
`default_nettype none
module sbl_loader_tb_top;
    import sbl_pkg::*;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, rxd = 1'b1, at_zero = 1'b0, rdy = 1'b1;
    sbl_src_e src = SBL_SRC_SPI;
    sbl_byte_s rx = '0, mrd;
    sbl_byte_s tx;
    sbl_ram_wr_s ram;
    sbl_mem_rd_s mreq;
    logic minit, mdone, claim, remap, swrst, br, done, fail, hit_br, hit_sw;
    logic [31:0] jump;
    logic [7:0] txq [$];
    logic [39:0] ramq [$];
    int fail_count = 0, compares = 0;
    always #5 sys_clk_in = ~sys_clk_in;
    sbl_loader sbl_loader_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
        .uart_rxd_in(rxd), .uart_enable_in(1'b1), .mem_enable_in(1'b1), .mem_src_in(src),
        .app_at_zero_in(at_zero), .rx_byte_in(rx), .tx_ready_in(rdy),
        .mem_init_done_in(mdone), .mem_rd_in(mrd), .tx_byte_out(tx), .ram_wr_out(ram),
        .mem_rd_out(mreq), .mem_init_out(minit), .uart_claim_out(claim),
        .remap_zero_out(remap), .sw_reset_out(swrst), .branch_out(br), .jump_addr_out(jump),
        .boot_done_out(done), .boot_fail_out(fail));
    sbl_mem_model sbl_mem_model_inst (.clk_in(sys_clk_in), .rst_n_in(rst_n_in), .rd_in(mreq),
        .init_in(minit), .rd_out(mrd), .init_done_out(mdone));
    // ****************************************************************
    // Monitors and helpers.
    // ****************************************************************
    always @(posedge sys_clk_in) begin
        if (tx.valid && rdy) txq.push_back(tx.data);
        if (ram.we) ramq.push_back({ram.addr, ram.data});
        if (br) hit_br = 1'b1;
        if (swrst) hit_sw = 1'b1;
    end
    task automatic tick();
        @(posedge sys_clk_in);
        #1;
    endtask
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reset();
        rst_n_in = 1'b0;
        repeat (16) tick();
        txq.delete();
        ramq.delete();
        hit_br = 1'b0;
        hit_sw = 1'b0;
        rst_n_in = 1'b1;
    endtask
    task automatic put_rx(input logic [7:0] b);
        rx = '{valid: 1'b1, data: b};
        tick();
        rx.valid = 1'b0;
        tick();
    endtask
    task automatic get_tx(input logic [7:0] exp);
        int n;
        n = 0;
        while (txq.size() == 0 && n < 300) begin
            tick();
            n++;
        end
        check(txq.size() != 0 ? {32'h0, txq.pop_front()} : 40'hdead, {32'h0, exp});
    endtask
    task automatic ram_chk(input int k, input logic [7:0] v);
        check(ramq.size() > k ? ramq[k] : 40'h0, {SBL_RAM_BASE + 32'(k), v});
    endtask
    task automatic wait_end();
        int n;
        n = 0;
        while (done !== 1'b1 && fail !== 1'b1 && n < 2000) begin
            tick();
            n++;
        end
        if (n >= 2000) fail_count++;
        repeat (3) tick();
    endtask
    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic test_uart();
        rxd = 1'b1;
        at_zero = 1'b0;
        rdy = 1'b0;
        reset();
        repeat (12) tick();
        check({tx.valid, tx.data}, {1'b1, SBL_STX});
        check(claim, 1'b1);
        rdy = 1'b1;
        get_tx(SBL_STX);
        put_rx(8'h55);
        put_rx(8'h02);
        put_rx(8'h00);
        get_tx(SBL_NACK);
        get_tx(SBL_STX);
        put_rx(SBL_SOH);
        put_rx(8'h02);
        put_rx(8'h00);
        get_tx(SBL_ACK);
        put_rx(8'ha5);
        put_rx(8'h3c);
        get_tx(8'h99);
        ram_chk(0, 8'ha5);
        ram_chk(1, 8'h3c);
        put_rx(SBL_ACK);
        wait_end();
        check(done, 1'b1);
        check(claim, 1'b0);
        check(jump, SBL_RAM_BASE);
        check({hit_br, remap, hit_sw}, 3'h4);
    endtask
    task automatic test_spi();
        rxd = 1'b0;
        at_zero = 1'b1;
        src = SBL_SRC_SPI;
        sbl_mem_model_inst.img[0] = SBL_SIG0;
        sbl_mem_model_inst.img[1] = SBL_SIG1;
        sbl_mem_model_inst.img[6] = 8'h00;
        sbl_mem_model_inst.img[7] = 8'h02;
        sbl_mem_model_inst.img[8] = 8'h11;
        sbl_mem_model_inst.img[9] = 8'h22;
        reset();
        wait_end();
        check(txq.size(), 0);
        check({done, fail}, 2'h2);
        check(ramq.size(), 2);
        ram_chk(0, 8'h11);
        ram_chk(1, 8'h22);
        check({hit_br, remap, hit_sw}, 3'h3);
    endtask
    task automatic test_eeprom();
        rxd = 1'b0;
        src = SBL_SRC_EEPROM;
        sbl_mem_model_inst.img[2] = 8'h00;
        sbl_mem_model_inst.img[3] = 8'h01;
        sbl_mem_model_inst.img[32] = 8'h5a;
        for (int k = 0; k < 3; k++) begin
            sbl_mem_model_inst.img[1] = (k == 2) ? 8'h51 : SBL_SIG1;
            sbl_mem_model_inst.img[4] = (k == 1) ? 8'h5a : 8'h00;
            reset();
            wait_end();
            check({done, fail}, (k == 1) ? 2'h2 : 2'h1);
            if (k == 1) ram_chk(0, 8'h5a);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #200us;
        fail_count++;
        end_sim();
    end
    initial begin
        tick();
        test_uart();
        test_spi();
        test_eeprom();
        end_sim();
    end
endmodule
`default_nettype wire

// File: sim/sbl_mem_model.sv
// Purpose: Byte-read model of the serial boot memory behind the loader.
// Assumes: Reads answer three cycles after a request; one read outstanding.
// Notes:   Read data toggles while not valid so stale bytes never pass.
`timescale 1ns/1ps
`default_nettype none
module sbl_mem_model
    import sbl_pkg::*;
(
    input  wire logic        clk_in,        // System clock.
    input  wire logic        rst_n_in,      // Reset, active low.
    input  wire sbl_mem_rd_s rd_in,         // Read request.
    input  wire logic        init_in,       // Init request pulse.
    output sbl_byte_s        rd_out,        // Read data.
    output logic             init_done_out  // Init done pulse.
);
    // ****************************************************************
    // Image store and read timing.
    // ****************************************************************
    logic [7:0] img [0:63];
    logic [1:0] rd_dly_r;
    logic [1:0] init_dly_r;
    logic [5:0] addr_r;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_dly_r      <= 2'h0;
            init_dly_r    <= 2'h0;
            addr_r        <= 6'h00;
            rd_out        <= '0;
            init_done_out <= 1'b0;
        end else begin
            init_done_out <= (init_dly_r == 2'h1);
            init_dly_r    <= init_in ? 2'h2 : (init_dly_r != 2'h0 ? init_dly_r - 2'h1 : 2'h0);
            rd_dly_r      <= rd_in.req ? 2'h2 : (rd_dly_r != 2'h0 ? rd_dly_r - 2'h1 : 2'h0);
            if (rd_in.req) begin
                addr_r <= rd_in.addr[5:0];
            end
            rd_out.valid <= (rd_dly_r == 2'h1);
            rd_out.data  <= (rd_dly_r == 2'h1) ? img[addr_r] : ~rd_out.data;
        end
    end
endmodule
`default_nettype wire
